// File: core/ccep_dev.sv
// Purpose: Cache controller end: RAM error handling, sticky irqs, idle
// Assumes: Error inputs arrive from same-clock RAM logic
// Notes: Overview of rules below
`timescale 1ns/1ps
`default_nettype none
module ccep_dev (
  input wire logic i_clk,
  input wire logic i_rst_b,
  ccep_if.dev bus,
  input wire logic i_irq_clear,
  output logic o_busy
);
  ccep_pkg::ccep_state_t state;
  ccep_pkg::ccep_state_t next_state;
  logic [3:0] op;
  logic evict_ok;
  logic [ccep_pkg::CCEP_IRQ_W-1:0] irq;
  logic [ccep_pkg::CCEP_IRQ_W-1:0] next_irq_set;
  logic finish;
  logic cancel;
  logic tag_fault;

  function automatic logic at_idle(input ccep_pkg::ccep_state_t s);
    at_idle = (s == ccep_pkg::CCEP_ST_IDLE);
  endfunction

  // Which steps an operation visits
  function automatic logic has_data(input logic [3:0] o);
    has_data = (o != 4'(ccep_pkg::CCEP_OP_INV));
  endfunction

  function automatic logic has_tag_write(input logic [3:0] o);
    has_tag_write = (o != 4'(ccep_pkg::CCEP_OP_CLEAN));
  endfunction

  assign tag_fault = bus.tag_par_err || bus.tag_ram_err;

  // Sequencing through the RAM steps
  always_comb begin
    next_state = state;
    finish = 1'b0;
    cancel = 1'b0;
    case (state)
      ccep_pkg::CCEP_ST_IDLE: begin
        if (bus.req_valid) begin
          next_state = ccep_pkg::CCEP_ST_RAMWAIT;
        end
      end
      ccep_pkg::CCEP_ST_RAMWAIT: begin
        if (!bus.ram_wait) begin
          next_state = ccep_pkg::CCEP_ST_TAGRD;
        end
      end
      ccep_pkg::CCEP_ST_TAGRD: begin
        if (tag_fault) begin
          cancel = 1'b1;
          next_state = ccep_pkg::CCEP_ST_IDLE;
        end else if (has_data(op)) begin
          next_state = ccep_pkg::CCEP_ST_DATARD;
        end else begin
          next_state = ccep_pkg::CCEP_ST_TAGWR;
        end
      end
      ccep_pkg::CCEP_ST_DATARD: begin
        // Completes regardless
        next_state = ccep_pkg::CCEP_ST_EVICT;
      end
      ccep_pkg::CCEP_ST_EVICT: begin
        if (has_tag_write(op)) begin
          next_state = ccep_pkg::CCEP_ST_TAGWR;
        end else begin
          finish = 1'b1;
          next_state = ccep_pkg::CCEP_ST_IDLE;
        end
      end
      ccep_pkg::CCEP_ST_TAGWR: begin
        if (op == 4'(ccep_pkg::CCEP_OP_ALLOC)) begin
          next_state = ccep_pkg::CCEP_ST_DATAWR;
        end else begin
          finish = 1'b1;
          next_state = ccep_pkg::CCEP_ST_IDLE;
        end
      end
      ccep_pkg::CCEP_ST_DATAWR: begin
        finish = 1'b1;
        next_state = ccep_pkg::CCEP_ST_IDLE;
      end
      default: begin
        next_state = ccep_pkg::CCEP_ST_IDLE;
      end
    endcase
  end

  // Error capture, one bit per RAM fault
  always_comb begin
    next_irq_set = '0;
    case (state)
      ccep_pkg::CCEP_ST_TAGRD: begin
        next_irq_set[ccep_pkg::CCEP_IRQ_TAG_PAR] = bus.tag_par_err;
        next_irq_set[ccep_pkg::CCEP_IRQ_TAG_RD] = bus.tag_ram_err;
      end
      ccep_pkg::CCEP_ST_DATARD: begin
        next_irq_set[ccep_pkg::CCEP_IRQ_DATA_PAR] = bus.data_par_err;
        next_irq_set[ccep_pkg::CCEP_IRQ_DATA_RD] = bus.data_ram_err;
      end
      ccep_pkg::CCEP_ST_TAGWR: begin
        next_irq_set[ccep_pkg::CCEP_IRQ_TAG_WR] =
          bus.tag_wr_err;
      end
      ccep_pkg::CCEP_ST_DATAWR: begin
        next_irq_set[ccep_pkg::CCEP_IRQ_DATA_WR] =
          bus.data_wr_err;
      end
      default: begin
        next_irq_set = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= ccep_pkg::CCEP_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operation captured when taken
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      op <= 4'h0;
    end else if (at_idle(state) && bus.req_valid) begin
      op <= bus.req_op;
    end
  end

  // Eviction dropped on data RAM error
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      evict_ok <= 1'b0;
    end else if (state == ccep_pkg::CCEP_ST_DATARD) begin
      evict_ok <= !bus.data_ram_err;
    end else if (at_idle(state)) begin
      evict_ok <= 1'b0;
    end
  end

  // Set wins over clear
  genvar g;
  generate
    for (g = 0; g < ccep_pkg::CCEP_IRQ_W; g++) begin : g_irq
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          irq[g] <= 1'b0;
        end else if (next_irq_set[g]) begin
          irq[g] <= 1'b1;
        end else if (i_irq_clear) begin
          irq[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Response pulse, one cycle per operation
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus.rsp_valid <= 1'b0;
    end else begin
      bus.rsp_valid <= finish || cancel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus.rsp_result <= ccep_pkg::CCEP_RES_DONE;
    end else begin
      bus.rsp_result <= cancel ? ccep_pkg::CCEP_RES_CANCEL
                               : ccep_pkg::CCEP_RES_DONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus.rsp_evicted <= 1'b0;
    end else begin
      bus.rsp_evicted <= finish && evict_ok;
    end
  end

  // Ready only between operations
  assign bus.req_ready = at_idle(state);
  assign bus.irq = irq;
  assign bus.combined_irq = |irq;
  // Idle only with nothing taken or pending
  assign bus.idle = at_idle(state)
                    && !bus.req_valid && !bus.rsp_valid;
  assign o_busy = !bus.idle;
endmodule
`default_nettype wire

// File: core/ccep_pkg.sv
// Purpose: Shared constants and types for the cache error and power blocks
// Assumes: One clock at 40 MHz, synchronous active-low reset
// Notes: Operation and error codes are shared by both ends
package ccep_pkg;

  // Operation kinds issued to the controller
  typedef enum logic [3:0] {
    CCEP_OP_ALLOC = 4'b0001,
    CCEP_OP_CLEAN = 4'b0010,
    CCEP_OP_INV = 4'b0100,
    CCEP_OP_CLINV = 4'b1000
  } ccep_op_t;

  // Controller states
  typedef enum logic [6:0] {
    CCEP_ST_IDLE = 7'b000_0001,
    CCEP_ST_RAMWAIT = 7'b000_0010,
    CCEP_ST_TAGRD = 7'b000_0100,
    CCEP_ST_DATARD = 7'b000_1000,
    CCEP_ST_EVICT = 7'b001_0000,
    CCEP_ST_TAGWR = 7'b010_0000,
    CCEP_ST_DATAWR = 7'b100_0000
  } ccep_state_t;

  // Outcome codes
  localparam logic [1:0] CCEP_RES_DONE = 2'h0;
  localparam logic [1:0] CCEP_RES_CANCEL = 2'h1;

  // Sticky interrupt bit positions
  localparam int CCEP_IRQ_TAG_PAR = 0;
  localparam int CCEP_IRQ_TAG_RD = 1;
  localparam int CCEP_IRQ_DATA_PAR = 2;
  localparam int CCEP_IRQ_DATA_RD = 3;
  localparam int CCEP_IRQ_TAG_WR = 4;
  localparam int CCEP_IRQ_DATA_WR = 5;
  localparam int CCEP_IRQ_W = 6;

  // Clock kept running after restart
  localparam int CCEP_CLK_HZ = 40_000_000;
  localparam int CCEP_HOLD_NS = 200;
  localparam int CCEP_HOLD_CYC =
    (CCEP_HOLD_NS * (CCEP_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] CCEP_HOLD_CNT = 8'(CCEP_HOLD_CYC);

endpackage

// File: core/ccep_if.sv
// Purpose: Link between cache controller and its power/master side
// Assumes: Single clock, no clocking block
// Notes: Power side gates the clock outside this code
`timescale 1ns/1ps
`default_nettype none
interface ccep_if (
  input wire logic i_clk
);
  logic req_valid;
  logic req_ready;
  logic [3:0] req_op;
  logic [1:0] rsp_result;
  logic rsp_valid;
  logic rsp_evicted;
  logic tag_par_err;
  logic tag_ram_err;
  logic data_par_err;
  logic data_ram_err;
  logic tag_wr_err;
  logic data_wr_err;
  logic ram_wait;
  logic idle;
  logic [5:0] irq;
  logic combined_irq;
  logic axi_valid;
  logic clk_run;
  logic rst_req_b;

  modport dev (
    input req_valid, req_op, tag_par_err, tag_ram_err, data_par_err,
    input data_ram_err, tag_wr_err, data_wr_err, ram_wait,
    output req_ready, rsp_result, rsp_valid, rsp_evicted, idle, irq,
    output combined_irq
  );
  modport sys (
    output req_valid, req_op, tag_par_err, tag_ram_err, data_par_err,
    output data_ram_err, tag_wr_err, data_wr_err, ram_wait,
    input req_ready, rsp_result, rsp_valid, rsp_evicted, idle, irq,
    input combined_irq,
    output clk_run, rst_req_b, axi_valid
  );
endinterface
`default_nettype wire

// File: core/ccep_sys.sv
// Purpose: System end: requester, clock gating and reset control
// Assumes: Masters' valid is same-clock logic
// Notes: clk_run gates the controller clock outside
`timescale 1ns/1ps
`default_nettype none
module ccep_sys (
  input wire logic i_clk,
  input wire logic i_rst_b,
  ccep_if.sys bus,
  input wire logic i_go,
  input wire logic [3:0] i_op,
  input wire logic i_tag_par_err,
  input wire logic i_tag_ram_err,
  input wire logic i_data_par_err,
  input wire logic i_data_ram_err,
  input wire logic i_tag_wr_err,
  input wire logic i_data_wr_err,
  input wire logic i_ram_wait,
  input wire logic i_axi_valid,
  input wire logic i_sleep_req,
  input wire logic i_wake_rst,
  output logic o_done,
  output logic o_masters_run
);
  logic [7:0] hold;
  logic run;
  logic rst_b;

  assign bus.req_valid = i_go;
  assign bus.req_op = i_op;
  assign bus.tag_par_err = i_tag_par_err;
  assign bus.tag_ram_err = i_tag_ram_err;
  assign bus.data_par_err = i_data_par_err;
  assign bus.data_ram_err = i_data_ram_err;
  assign bus.tag_wr_err = i_tag_wr_err;
  assign bus.data_wr_err = i_data_wr_err;
  assign bus.ram_wait = i_ram_wait;
  assign bus.axi_valid = i_axi_valid;

  // Restart clock same cycle as valid
  assign bus.clk_run = run || i_axi_valid || i_go;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      hold <= 8'h00;
      run <= 1'b1;
    end else if (i_axi_valid || i_go) begin
      hold <= ccep_pkg::CCEP_HOLD_CNT;
      run <= 1'b1;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end else begin
      run <= !(i_sleep_req && bus.idle);
    end
  end

  // Dormant exit by reset, masters held
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rst_b <= 1'b0;
    end else begin
      rst_b <= !i_wake_rst;
    end
  end
  assign bus.rst_req_b = rst_b;

  // Masters clocked only once controller runs
  assign o_masters_run = rst_b && bus.clk_run;
  assign o_done = bus.rsp_valid;
endmodule
`default_nettype wire

// File: test/ccep_props.sv
// Purpose: Interface checks for the cache error link
// Assumes: One clock, sync active-low reset
// Notes: Error levels held for a whole operation
`timescale 1ns/1ps
`default_nettype none
module ccep_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [1:0] rsp_result,
  input wire logic rsp_valid,
  input wire logic rsp_evicted,
  input wire logic tag_par_err,
  input wire logic tag_ram_err,
  input wire logic data_par_err,
  input wire logic data_ram_err,
  input wire logic tag_wr_err,
  input wire logic data_wr_err,
  input wire logic ram_wait,
  input wire logic idle,
  input wire logic [5:0] irq,
  input wire logic combined_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_go(m);
    req_valid && req_ready && (req_op & m) != 4'h0 && !ram_wait ##1 !ram_wait;
  endsequence
  sequence s_tag_ok(m);
    s_go(m) ##1 !(tag_par_err || tag_ram_err);
  endsequence
  sequence s_alloc;
    s_tag_ok(4'h1) ##1 !(data_par_err || data_ram_err);
  endsequence
  property p_comb;
    combined_irq == (|irq);
  endproperty
  a_comb: assert property (p_comb)
    else $error("combined irq wrong");
  property p_sticky;
    |($past(irq) & ~irq) |-> irq == 6'h00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq bit lost");
  property p_busy;
    req_valid && req_ready |=> !idle;
  endproperty
  a_busy: assert property (p_busy) else $error("idle while busy");
  property p_tag;
    s_go(4'hf) ##1 (tag_par_err || tag_ram_err) |->
      ##[1:6] rsp_valid && rsp_result == ccep_pkg::CCEP_RES_CANCEL;
  endproperty
  a_tag: assert property (p_tag) else $error("no cancel");
  property p_data;
    s_tag_ok(4'hb) ##1 data_ram_err |-> ##[1:6]
      rsp_valid && rsp_result == ccep_pkg::CCEP_RES_DONE && !rsp_evicted;
  endproperty
  a_data: assert property (p_data)
    else $error("bad data err");
  property p_twr;
    s_alloc ##2 tag_wr_err |-> ##[1:2] irq[ccep_pkg::CCEP_IRQ_TAG_WR];
  endproperty
  a_twr: assert property (p_twr) else $error("no tag wr irq");
  property p_dwr;
    s_alloc ##2 !tag_wr_err ##1 data_wr_err |->
      ##[1:2] irq[ccep_pkg::CCEP_IRQ_DATA_WR];
  endproperty
  a_dwr: assert property (p_dwr) else $error("no data wr irq");
  property p_wait;
    req_valid && req_ready ##1 ram_wait [*4] |=> !rsp_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("ran during wait");
endmodule
`default_nettype wire

// File: test/ccep_test.sv
// Purpose: Self-checking bench joining both ends
// Assumes: 40 MHz clock, reset held 16 cycles
// Notes: One injected error level per operation
`timescale 1ns/1ps
`default_nettype none
module ccep_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic [3:0] op = 4'h1;
  logic [5:0] inj = 6'h00;
  logic wt = 1'b0;
  logic axv = 1'b0;
  logic clr = 1'b0;
  logic sleep = 1'b0;
  logic wake = 1'b0;
  logic busy;
  logic done;
  logic mrun;
  logic [31:0] lfsr = 32'h8d11_77a7;
  logic [14:0] q;
  logic [14:0] expq[$];
  int err_total = 0;
  int compares = 0;
  ccep_if cif (.i_clk(clk));
  ccep_dev u_ccep_dev (.i_clk(clk), .i_rst_b(rst_b), .bus(cif.dev),
    .i_irq_clear(clr), .o_busy(busy));
  ccep_sys u_ccep_sys (.i_clk(clk), .i_rst_b(rst_b), .bus(cif.sys),
    .i_go(go), .i_op(op), .i_tag_par_err(inj[0]), .i_tag_ram_err(inj[1]),
    .i_data_par_err(inj[2]), .i_data_ram_err(inj[3]),
    .i_tag_wr_err(inj[4]), .i_data_wr_err(inj[5]), .i_ram_wait(wt),
    .i_axi_valid(axv), .i_sleep_req(sleep), .i_wake_rst(wake),
    .o_done(done), .o_masters_run(mrun));
  ccep_props u_ccep_props (.i_clk(clk), .i_rst_b(rst_b),
    .req_valid(cif.req_valid), .req_ready(cif.req_ready),
    .req_op(cif.req_op), .rsp_result(cif.rsp_result),
    .rsp_valid(cif.rsp_valid), .rsp_evicted(cif.rsp_evicted),
    .tag_par_err(cif.tag_par_err), .tag_ram_err(cif.tag_ram_err),
    .data_par_err(cif.data_par_err), .data_ram_err(cif.data_ram_err),
    .tag_wr_err(cif.tag_wr_err), .data_wr_err(cif.data_wr_err),
    .ram_wait(cif.ram_wait), .idle(cif.idle), .irq(cif.irq),
    .combined_irq(cif.combined_irq));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Result, irq mask, irq expected; skipped steps raise nothing
  function automatic logic [14:0] exp_of(input logic [3:0] o, input int e);
    logic [5:0] m;
    logic [5:0] x;
    logic ev;
    m = 6'h3f;
    x = 6'h00;
    ev = (o != 4'h4) && !(e inside {0, 1, 3});
    if (e >= 0) begin
      m = 6'h01 << e;
      x = m;
      if ((o == 4'h4 && e inside {2, 3}) || (o == 4'h2 && e == 4)) x = 6'h00;
      if (o != 4'h1 && e == 5) x = 6'h00;
    end
    return {ev, (e == 0 || e == 1) ? ccep_pkg::CCEP_RES_CANCEL :
      ccep_pkg::CCEP_RES_DONE, m, x};
  endfunction
  task automatic results();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_res(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t result %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t irq %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run_op(input logic [3:0] o, input int e, input int w);
    int n;
    n = 0;
    @(negedge clk);
    op = o;
    inj = (e >= 0) ? 6'h01 << e : 6'h00;
    wt = (w > 0);
    go = 1'b1;
    expq.push_back(exp_of(o, e));
    @(negedge clk);
    go = 1'b0;
    chk_bit(busy, 1'b1);
    while (done !== 1'b1) begin
      if (n >= 60) begin
        err_total++;
        $display("ERROR %0t no response", $time);
        results();
      end
      if (n >= w) wt = 1'b0;
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    clr = 1'b1;
    inj = 6'h00;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk_irq(cif.irq, 6'h00);
    chk_bit(busy, 1'b0);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 && expq.size() > 0) begin
      q = expq.pop_front();
      chk_res(cif.rsp_result, q[13:12]);
      chk_bit(cif.rsp_evicted, q[14]);
      @(posedge clk);
      chk_irq(cif.irq & q[11:6], q[5:0]);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    for (int o = 0; o < 4; o++) begin
      for (int e = -1; e < 6; e++) begin
        run_op(4'h1 << o, e, 0);
      end
    end
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      run_op(4'h1 << lfsr[1:0], int'(lfsr[4:2]) % 7 - 1, int'(lfsr[7:5]));
    end
    @(negedge clk);
    sleep = 1'b1;
    repeat (12) @(negedge clk);
    chk_bit(cif.clk_run, 1'b0);
    axv = 1'b1;
    #1;
    chk_bit(cif.clk_run, 1'b1);
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      axv = 1'b0;
      chk_bit(cif.clk_run, 1'b1);
    end
    repeat (6) @(negedge clk);
    chk_bit(cif.clk_run, 1'b0);
    sleep = 1'b0;
    wake = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(mrun, 1'b0);
    wake = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(mrun, 1'b1);
    results();
  end
endmodule
`default_nettype wire
